// ### bench/dte_source_model.sv
`timescale 1ns/1ps
module dte_source_model #(
  parameter int NCH = 2,
  parameter int SW = 16
) (
  input wire logic ref_clk,
  input wire logic [3:0] gap,
  input wire logic set_en,
  input wire logic [2:0] set_idx,
  input wire logic [SW-1:0] set_val,
  output logic sample_valid,
  output logic [NCH*SW-1:0] samples,
  output logic [SW-1:0] ext_a,
  output logic [SW-1:0] ext_b
);
  logic [SW-1:0] val_ff [NCH+2] = '{default: '0};
  logic [3:0] cnt_ff = 4'h0;
  // A sample every gap+1 cycles; between samples the lines show inverted junk
  always @(posedge ref_clk) begin
    cnt_ff <= (cnt_ff >= gap) ? 4'h0 : cnt_ff + 4'h1;
    if (set_en) val_ff[set_idx] <= set_val;
  end
  always_comb begin
    sample_valid = (cnt_ff == 4'h0);
    for (int i = 0; i < NCH; i++) samples[i*SW +: SW] = sample_valid ? val_ff[i] : ~val_ff[i];
    ext_a = sample_valid ? val_ff[NCH] : ~val_ff[NCH];
    ext_b = sample_valid ? val_ff[NCH+1] : ~val_ff[NCH+1];
  end
endmodule // dte_source_model

// ### bench/dte_trigger_engine_bench.sv
`timescale 1ns/1ps
module dte_trigger_engine_bench;
  import dte_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [31:0] rdata;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sv;
  logic [31:0] smp;
  logic [15:0] ea;
  logic [15:0] eb;
  logic sync_in = 1'b0;
  logic trig;
  logic [1:0] mio;
  logic [3:0] gap = 4'h0;
  logic set_en = 1'b0;
  logic [2:0] set_idx = '0;
  logic [15:0] set_val = '0;
  int n_fail = 0;
  int checks = 0;
  int hits = 0;
  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (trig === 1'b1) hits++;
  dte_trigger_engine #(.NCH(2), .SW(16)) i_dte_trigger_engine (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
    .sample_valid(sv), .input_channel_samples(smp), .external_trigger_in_a(ea),
    .external_trigger_in_b(eb), .sync_trig_in(sync_in), .sync_trig_out(), .trigger_out(trig),
    .mio_out(mio));
  dte_source_model #(.NCH(2), .SW(16)) i_dte_source_model (.ref_clk(ref_clk), .gap(gap),
    .set_en(set_en), .set_idx(set_idx), .set_val(set_val), .sample_valid(sv), .samples(smp),
    .ext_a(ea), .ext_b(eb));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    reg_addr <= a;
    reg_wdata <= 32'(d);
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input int e);
    reg_addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1 chk(rdata, 32'(e));
    @(posedge ref_clk);
  endtask
  task automatic watch(input int b, input int e);
    repeat (12) @(posedge ref_clk);
    chk(32'(hits - b), 32'(e));
    if (hits - b < e) close_out();
  endtask
  task automatic step(input int i, input int v, input int e);
    int b;
    b = hits;
    set_idx <= 3'(i);
    set_val <= 16'(v);
    set_en <= 1'b1;
    @(posedge ref_clk);
    set_en <= 1'b0;
    watch(b, e);
  endtask
  task automatic src(input int s, input int m, input int a, input int lb);
    wr(OFS_SRC_BASE + 12'(s << SRC_STRIDE_LOG2), m);
    wr(OFS_SRC_BASE + 12'((s << SRC_STRIDE_LOG2) + 4), a);
    wr(OFS_SRC_BASE + 12'((s << SRC_STRIDE_LOG2) + 8), lb);
  endtask
  task automatic t_modes();
    int t [11][7] = '{'{0, 'h01, 100, 0, 50, 150, 1}, '{1, 'h11, 100, 0, 50, 150, 0},
      '{2, 'h11, 100, 0, 150, 50, 1}, '{3, 'h21, 100, 0, 150, 50, 1},
      '{0, 'h03, 200, 100, 50, 150, 1}, '{0, 'h03, 200, 100, 150, 250, 0},
      '{1, 'h04, 200, 100, 150, 250, 1}, '{0, 'h05, 100, 0, 50, 150, 1},
      '{0, 'h06, 100, 0, 150, 50, 1}, '{0, 'h07, 200, 100, 250, 150, 1},
      '{0, 'h08, 200, 100, 150, 50, 1}};
    gap <= 4'h2;
    foreach (t[r]) begin
      src(t[r][0], t[r][1], t[r][2], t[r][3]);
      wr(OFS_OR_MASK, 1 << t[r][0]);
      step(t[r][0], t[r][4], 0);
      wr(OFS_CTRL, 1);
      step(t[r][0], t[r][5], t[r][6]);
      rd(OFS_STATUS, t[r][6] ? 2 : 1);
      wr(OFS_CTRL, 2);
    end
  endtask
  task automatic t_rearm();
    wr(OFS_OR_MASK, 8);
    src(3, 0, 200, 100);
    step(3, 150, 0);
    wr(OFS_SRC_BASE + 12'h030, 'h02);
    wr(OFS_CTRL, 1);
    step(3, 250, 0);
    step(3, 50, 0);
    step(3, 150, 0);
    step(3, 250, 1);
    wr(OFS_CTRL, 1);
    step(3, 150, 0);
    step(3, 250, 0);
    wr(OFS_CTRL, 2);
  endtask
  task automatic t_and();
    gap <= 4'h0;
    src(0, 'h05, 100, 0);
    src(1, 'h01, 100, 0);
    wr(OFS_OR_MASK, 0);
    wr(OFS_AND_MASK, 3);
    wr(OFS_CFG, 1);
    step(0, 50, 0);
    step(1, 50, 0);
    wr(OFS_CTRL, 1);
    step(1, 150, 0);
    step(1, 50, 0);
    step(0, 150, 0);
    step(1, 150, 1);
    rd(OFS_TRIG_POS, 41);
    wr(OFS_CFG, 2);
  endtask
  task automatic t_cmds();
    int b;
    wr(OFS_MIO_SEL, 'h6);
    for (int k = 0; k < 6; k++) begin
      if (k % 2 == 1) begin
        wr(OFS_CTRL, 1);
        #1 chk(32'(mio), 32'h2);
        @(posedge ref_clk);
      end
      b = hits;
      sync_in <= (k >= 4);
      if (k < 4) wr(OFS_CTRL, 4 << (k / 2));
      else @(posedge ref_clk);
      sync_in <= 1'b0;
      watch(b, k % 2);
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(OFS_OR_MASK, 0);
    wr(OFS_OR_MASK, 'hff);
    rd(OFS_OR_MASK, 'hf);
    rd(12'h020, 0);
    t_modes();
    t_rearm();
    t_and();
    t_cmds();
    close_out();
  end
endmodule // dte_trigger_engine_bench

// ### bench/dte_trigger_engine_properties.sv
`timescale 1ns/1ps
module dte_trigger_engine_checker #(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [dte_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dte_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dte_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sync_trig_out,
  input wire logic trigger_out,
  input wire logic [dte_pkg::MIO_LINES-1:0] mio_out
);
  import dte_pkg::*;
  logic [NCH+1:0] or_ff;
  logic [1:0] sel_ff;
  logic fired_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      or_ff <= '0;
      sel_ff <= '0;
      fired_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_OR_MASK) or_ff <= reg_wdata[NCH+1:0];
      if (reg_wr && reg_addr == OFS_MIO_SEL) sel_ff <= reg_wdata[1:0];
      if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START]) fired_ff <= 1'b0;
      else if (trigger_out) fired_ff <= 1'b1;
    end
  end
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read slot");
  chk_rd_zero: assert property (reg_rd && (reg_addr == OFS_CTRL || reg_addr == 12'h020)
    |=> reg_rdata == '0) else $error("unreadable address not zero");
  chk_or_readback: assert property (
    reg_rd && reg_addr == OFS_OR_MASK |=> reg_rdata == 32'(or_ff))
    else $error("mask readback wrong");
  chk_trig_pair: assert property (trigger_out == sync_trig_out)
    else $error("trigger outputs differ");
  chk_trig_single: assert property (trigger_out |=> !trigger_out)
    else $error("trigger pulse too long");
  chk_rst_quiet: assert property (disable iff (1'b0) rst |=> reg_rdata == '0
    && !trigger_out && mio_out == '0) else $error("outputs not cleared by reset");
  chk_mio_trig: assert property (
    sel_ff == 2'h2 && $stable(sel_ff) |-> mio_out[0] == trigger_out)
    else $error("trigger line wrong");
  chk_status_done: assert property (
    fired_ff && reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[1:0] == 2'b10)
    else $error("status not done");
endmodule // dte_trigger_engine_checker
bind dte_trigger_engine dte_trigger_engine_checker #(.NCH(NCH)) i_dte_trigger_engine_checker (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_trig_out(sync_trig_out),
  .trigger_out(trigger_out), .mio_out(mio_out));

// ### core/dte_trigger_engine.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dte_trigger_engine #(
  parameter int NCH = 4,
  parameter int SW = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [dte_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dte_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dte_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [NCH*SW-1:0] input_channel_samples,
  input wire logic [SW-1:0] external_trigger_in_a,
  input wire logic [SW-1:0] external_trigger_in_b,
  input wire logic sync_trig_in,
  output logic sync_trig_out,
  output logic trigger_out,
  output logic [dte_pkg::MIO_LINES-1:0] mio_out
);
  import dte_pkg::*;

  localparam int NSRC = NCH + 2;

  // Refuse sizes that the register map and the mask fields cannot hold
  if (NCH < 1 || NSRC > 28 || SW < 2 || SW > 32) begin : g_bad_size
    $error("dte_trigger_engine: unsupported NCH or SW");
  end

  //--------------------------------------------------------------------
  // Source gathering
  //--------------------------------------------------------------------
  logic [SW-1:0] src_smp [NSRC];
  logic [SW-1:0] src_lvl_a [NSRC];
  logic [SW-1:0] src_lvl_b [NSRC];
  logic [5:0] src_mode [NSRC];
  logic [NSRC-1:0] src_evt;
  logic [NSRC-1:0] src_gate;

  assign src_smp[NCH] = external_trigger_in_a;
  assign src_smp[NCH+1] = external_trigger_in_b;

  //--------------------------------------------------------------------
  // Register decode
  //--------------------------------------------------------------------
  wire src_hit = reg_addr >= OFS_SRC_BASE;
  wire [ADDR_W-1:0] src_off = reg_addr - OFS_SRC_BASE;
  wire [ADDR_W-1:0] src_idx = src_off >> SRC_STRIDE_LOG2;
  wire [1:0] src_fld = src_off[3:2];
  wire ctrl_we = reg_wr && reg_addr == OFS_CTRL;
  wire start_cmd = ctrl_we && reg_wdata[CTRL_START];
  wire stop_cmd = ctrl_we && reg_wdata[CTRL_STOP];
  wire sw_trig = ctrl_we && reg_wdata[CTRL_SW_TRIG];
  wire force_trig = ctrl_we && reg_wdata[CTRL_FORCE];

  logic [1:0] cfg_ff;
  logic [NSRC-1:0] or_mask_ff;
  logic [NSRC-1:0] and_mask_ff;
  logic [2*MIO_LINES-1:0] mio_sel_ff;
  logic [31:0] trig_pos_ff;
  logic [31:0] smp_cnt_ff;
  logic and_prev_ff;
  logic [DATA_W-1:0] rdata_ff;
  dte_run_type run_ff;
  dte_run_type nxt_run;

  //--------------------------------------------------------------------
  // Per-source detectors
  //--------------------------------------------------------------------
  function automatic logic gate_of(input dte_mode_type m, input logic a, input logic b);
    logic inw;
    inw = b && !a;
    case (m)
      MODE_HI_LEVEL: gate_of = a;
      MODE_LO_LEVEL: gate_of = !a;
      MODE_IN_WIN: gate_of = inw;
      MODE_OUT_WIN: gate_of = !inw;
      default: gate_of = 1'b0;
    endcase
  endfunction

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    logic [5:0] mode_ff;
    logic [SW-1:0] lvl_a_ff;
    logic [SW-1:0] lvl_b_ff;
    logic prev_a_ff;
    logic prev_b_ff;
    logic armed_ff;
    logic nxt_armed;
    logic evt;
    wire we = reg_wr && src_hit && src_idx == ADDR_W'(i);
    wire dte_mode_type mode = dte_mode_type'(mode_ff[SLOPE_LSB-1:MODE_LSB]);
    wire [1:0] slope = mode_ff[SLOPE_LSB+1:SLOPE_LSB];
    wire rise_en = slope == SLOPE_RISE || slope == SLOPE_BOTH;
    wire fall_en = slope == SLOPE_FALL || slope == SLOPE_BOTH;
    // Two comparators per source
    wire above_a = src_smp[i] > lvl_a_ff;
    wire above_b = src_smp[i] > lvl_b_ff;
    // Crossings between the previous and the current sample
    wire up_a = !prev_a_ff && above_a;
    wire dn_a = prev_a_ff && !above_a;
    wire up_b = !prev_b_ff && above_b;
    wire dn_b = prev_b_ff && !above_b;
    wire hit_a = (rise_en && up_a) || (fall_en && dn_a);
    wire hit_b = (rise_en && up_b) || (fall_en && dn_b);
    // Level A is the upper bound, level B the lower bound
    wire in_now = above_b && !above_a;
    wire in_was = prev_b_ff && !prev_a_ff;
    wire gate_now = gate_of(mode, above_a, above_b);
    wire gate_was = gate_of(mode, prev_a_ff, prev_b_ff);

    always_comb begin
      case (mode)
        MODE_EDGE: evt = hit_a;
        MODE_REARM: evt = armed_ff && hit_a;
        MODE_WIN_ENTER: evt = !in_was && in_now;
        MODE_WIN_EXIT: evt = in_was && !in_now;
        MODE_HI_LEVEL, MODE_LO_LEVEL: evt = gate_now && !gate_was;
        MODE_IN_WIN, MODE_OUT_WIN: evt = gate_now && !gate_was;
        default: evt = 1'b0;
      endcase
    end

    always_comb begin
      nxt_armed = armed_ff;
      if (mode != MODE_REARM) begin
        nxt_armed = 1'b0;
      end else if (sample_valid && evt) begin
        nxt_armed = 1'b0;
      end else if (sample_valid && hit_b) begin
        nxt_armed = 1'b1;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        mode_ff <= RST_MODE;
        lvl_a_ff <= '0;
        lvl_b_ff <= '0;
        prev_a_ff <= 1'b0;
        prev_b_ff <= 1'b0;
        armed_ff <= 1'b0;
      end else begin
        if (we && src_fld == SRC_FLD_MODE) mode_ff <= reg_wdata[5:0];
        if (we && src_fld == SRC_FLD_LVL_A) lvl_a_ff <= reg_wdata[SW-1:0];
        if (we && src_fld == SRC_FLD_LVL_B) lvl_b_ff <= reg_wdata[SW-1:0];
        if (sample_valid) begin
          prev_a_ff <= above_a;
          prev_b_ff <= above_b;
        end
        armed_ff <= nxt_armed;
      end
    end

    if (i < NCH) begin : g_chan
      assign src_smp[i] = input_channel_samples[i*SW +: SW];
    end
    assign src_mode[i] = mode_ff;
    assign src_lvl_a[i] = lvl_a_ff;
    assign src_lvl_b[i] = lvl_b_ff;
    assign src_evt[i] = sample_valid && evt;
    // Gate modes hand the level to AND logic, others their event
    // Between samples the inputs are not valid, so the last sampled gate is held
    assign src_gate[i] = (gate_of(mode, 1'b1, 1'b0) || gate_of(mode, 1'b0, 1'b1)) ?
                         (sample_valid ? gate_now : gate_was) : src_evt[i];
  end

  //--------------------------------------------------------------------
  // Trigger logic
  //--------------------------------------------------------------------
  wire sync_evt = cfg_ff[CFG_SYNC_EN] && sync_trig_in;
  wire or_fire = |(or_mask_ff & src_evt) || sync_evt ||
                 sw_trig || force_trig;
  wire and_now = cfg_ff[CFG_AND_EN] && and_mask_ff != '0 &&
                 &(~and_mask_ff | src_gate);
  wire and_fire = and_now && !and_prev_ff;
  wire fire = run_ff == RUN_ARMED && (or_fire || and_fire);

  always_comb begin
    nxt_run = run_ff;
    case (run_ff)
      RUN_IDLE: if (start_cmd) nxt_run = RUN_ARMED;
      RUN_ARMED: begin
        if (fire) begin
          nxt_run = RUN_DONE;
        end else if (stop_cmd) begin
          nxt_run = RUN_IDLE;
        end
      end
      RUN_DONE: if (start_cmd) nxt_run = RUN_ARMED;
      default: nxt_run = RUN_IDLE;
    endcase
  end

  // MIO line sources
  wire [3:0] mio_src = {and_now, fire, run_ff == RUN_ARMED, 1'b0};
  logic [MIO_LINES-1:0] nxt_mio;
  for (genvar m = 0; m < MIO_LINES; m++) begin : g_mio
    assign nxt_mio[m] = mio_src[mio_sel_ff[2*m +: 2]];
  end

  //--------------------------------------------------------------------
  // Read mux
  //--------------------------------------------------------------------
  wire src_in_range = src_hit && src_idx < ADDR_W'(NSRC);
  wire [$clog2(NSRC)-1:0] ridx = src_idx[$clog2(NSRC)-1:0];
  wire [DATA_W-1:0] src_rd =
    !src_in_range ? RST_WORD :
    src_fld == SRC_FLD_MODE ? DATA_W'(src_mode[ridx]) :
    src_fld == SRC_FLD_LVL_A ? DATA_W'(src_lvl_a[ridx]) :
    src_fld == SRC_FLD_LVL_B ? DATA_W'(src_lvl_b[ridx]) : RST_WORD;
  wire [DATA_W-1:0] rd_mux =
    src_hit ? src_rd :
    reg_addr == OFS_CFG ? DATA_W'(cfg_ff) :
    reg_addr == OFS_OR_MASK ? DATA_W'(or_mask_ff) :
    reg_addr == OFS_AND_MASK ? DATA_W'(and_mask_ff) :
    reg_addr == OFS_STATUS ? DATA_W'({and_now, run_ff == RUN_DONE, run_ff == RUN_ARMED}) :
    reg_addr == OFS_TRIG_POS ? trig_pos_ff :
    reg_addr == OFS_MIO_SEL ? DATA_W'(mio_sel_ff) : RST_WORD;

  //--------------------------------------------------------------------
  // Global registers
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_ff <= '0;
      or_mask_ff <= '0;
      and_mask_ff <= '0;
      mio_sel_ff <= '0;
      rdata_ff <= RST_WORD;
    end else begin
      if (reg_wr && reg_addr == OFS_CFG) cfg_ff <= reg_wdata[1:0];
      if (reg_wr && reg_addr == OFS_OR_MASK) or_mask_ff <= reg_wdata[NSRC-1:0];
      if (reg_wr && reg_addr == OFS_AND_MASK) and_mask_ff <= reg_wdata[NSRC-1:0];
      if (reg_wr && reg_addr == OFS_MIO_SEL) mio_sel_ff <= reg_wdata[2*MIO_LINES-1:0];
      rdata_ff <= reg_rd ? rd_mux : RST_WORD;
    end
  end

  // Sample count since arming; the count at the firing sample is kept as trigger position
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_ff <= RUN_IDLE;
      smp_cnt_ff <= RST_WORD;
      trig_pos_ff <= RST_WORD;
      and_prev_ff <= 1'b0;
      trigger_out <= 1'b0;
      sync_trig_out <= 1'b0;
      mio_out <= '0;
    end else begin
      run_ff <= nxt_run;
      if (run_ff != RUN_ARMED && start_cmd) begin
        smp_cnt_ff <= RST_WORD;
      end else if (run_ff == RUN_ARMED && sample_valid) begin
        smp_cnt_ff <= smp_cnt_ff + 32'h0000_0001;
      end
      if (fire) trig_pos_ff <= smp_cnt_ff;
      and_prev_ff <= and_now;
      trigger_out <= fire;
      sync_trig_out <= fire;
      mio_out <= nxt_mio;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule // dte_trigger_engine

// ### pkg/dte_pkg.sv
//----------------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------------
// Behaviour
// - Two level comparators per trigger source
// - Sources: all channels plus both externals
// - Software trigger request acts as source
// - Edge mode fires on threshold crossing
// - Edge slope: rising, falling or both
// - Re-arm: arm on arm-level crossing first
// - Armed: fire on trigger-level crossing, same slope
// - Re-arm fire disarms; needs new arm crossing
// - Window modes use both levels as bounds
// - Window enter fires on entering window
// - Window exit fires on leaving window
// - Level and window gates feed AND logic
// - High gate asserted while above level
// - Low gate while below; alone fires falling
// - Configurable AND and OR trigger combining
// - OR fires on any selected input
// - AND fires when all selected inputs asserted
// - Trigger sample position kept as sample count since arming
// - MIO lines show run state, trigger pulse
// - Cross-trigger with up to seven cards
package dte_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CFG = 12'h004;
  localparam logic [11:0] OFS_OR_MASK = 12'h008;
  localparam logic [11:0] OFS_AND_MASK = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_TRIG_POS = 12'h014;
  localparam logic [11:0] OFS_MIO_SEL = 12'h018;
  localparam logic [11:0] OFS_SRC_BASE = 12'h040;
  localparam int SRC_STRIDE_LOG2 = 4;
  localparam logic [1:0] SRC_FLD_MODE = 2'h0;
  localparam logic [1:0] SRC_FLD_LVL_A = 2'h1;
  localparam logic [1:0] SRC_FLD_LVL_B = 2'h2;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_SW_TRIG = 2;
  localparam int CTRL_FORCE = 3;
  localparam int CFG_AND_EN = 0;
  localparam int CFG_SYNC_EN = 1;
  localparam int ST_RUN = 0;
  localparam int ST_DONE = 1;
  localparam int ST_AND = 2;
  localparam int MODE_LSB = 0;
  localparam int SLOPE_LSB = 4;
  localparam int MIO_LINES = 2;
  localparam logic [5:0] RST_MODE = 6'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [3:0] {
    MODE_OFF, MODE_EDGE, MODE_REARM, MODE_WIN_ENTER, MODE_WIN_EXIT,
    MODE_HI_LEVEL, MODE_LO_LEVEL, MODE_IN_WIN, MODE_OUT_WIN
  } dte_mode_type;
  typedef enum logic [1:0] {SLOPE_RISE, SLOPE_FALL, SLOPE_BOTH} dte_slope_type;
  typedef enum logic [1:0] {MIO_LOW, MIO_RUN, MIO_TRIG, MIO_AND} dte_mio_type;
  typedef enum logic [1:0] {RUN_IDLE, RUN_ARMED, RUN_DONE} dte_run_type;
endpackage
